// file: lpm_pkg.sv
// Shared constants, mode codes and carrier types for the operating-mode sequencer.
package lpm_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W  = 21;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] SPEED_CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] SYS_CLK_SEL_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] TIMER_A_MODE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] FRAME_CFG_OFS    = 8'h0C;
  localparam logic [ADDR_W-1:0] MODE_STATUS_OFS  = 8'h10;

  // Field positions.
  localparam int unsigned LOW_SPEED_BIT     = 0;
  localparam int unsigned DIRECT_XFER_BIT   = 3;
  localparam int unsigned SUB_SPEED_BIT     = 2;
  localparam int unsigned SUBOSC_HALT_BIT   = 3;
  localparam int unsigned WATCH_SELECT_BIT  = 3;
  localparam int unsigned RAM_VALID_BIT     = 3;
  localparam int unsigned MODE_LSB          = 4;

  // Values after reset and bus response codes.
  localparam logic [1:0] FRAME_SEL_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Interrupt frame lengths and oscillator settling times.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned FRAME0_NS     = 244140;
  localparam int unsigned FRAME1_NS     = 15625000;
  localparam int unsigned FRAME2_NS     = 62500000;
  localparam int unsigned SETTLE0_NS    = 122070;
  localparam int unsigned SETTLE1_NS    = 7812500;
  localparam int unsigned SETTLE2_NS    = 31250000;
  localparam int unsigned FRAME0_CYC    = FRAME0_NS / CLK_PERIOD_NS;
  localparam int unsigned FRAME1_CYC    = FRAME1_NS / CLK_PERIOD_NS;
  localparam int unsigned FRAME2_CYC    = FRAME2_NS / CLK_PERIOD_NS;
  localparam int unsigned SETTLE0_CYC   = (SETTLE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE1_CYC   = (SETTLE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE2_CYC   = (SETTLE2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MODE_ACTIVE    = 3'h0,
    MODE_STANDBY   = 3'h1,
    MODE_STOP      = 3'h2,
    MODE_WATCH     = 3'h3,
    MODE_SUBACTIVE = 3'h4,
    MODE_SETTLE    = 3'h5
  } mode_e;

  // Clock gating, oscillator and pin control toward the rest of the chip.
  typedef struct packed {
    logic main_osc_en;
    logic sub_osc_en;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic adc_clk_en;
    logic port_hold;
    logic pins_hiz;
    logic core_reset;
  } clk_ctrl_s;

endpackage

// file: low_power_mode_sequencer.sv
// Operating-mode sequencer with its AXI4-Lite register slave.
`timescale 1ns/1ps

module low_power_mode_sequencer #(
  parameter int unsigned FRAME0_CYC  = lpm_pkg::FRAME0_CYC,
  parameter int unsigned FRAME1_CYC  = lpm_pkg::FRAME1_CYC,
  parameter int unsigned FRAME2_CYC  = lpm_pkg::FRAME2_CYC,
  parameter int unsigned SETTLE0_CYC = lpm_pkg::SETTLE0_CYC,
  parameter int unsigned SETTLE1_CYC = lpm_pkg::SETTLE1_CYC,
  parameter int unsigned SETTLE2_CYC = lpm_pkg::SETTLE2_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [lpm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [lpm_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       doze_instr,
  input  wire logic                       deep_sleep_instr,
  input  wire logic                       irq_global_enable,
  input  wire logic                       irq_unmasked_pending,
  input  wire logic                       irq_request,
  input  wire logic                       timer_a_overflow,
  input  wire logic                       deep_sleep_wake_n,
  input  wire logic                       ext_irq0_n,
  output lpm_pkg::mode_e                  mode_q,
  output lpm_pkg::clk_ctrl_s              clk_ctrl_q,
  output logic                            sub_speed_q,
  output logic                            restart_zero_q,
  output logic                            sleep_nop_q,
  output logic                            irq_strobe_q,
  output logic                            timer_a_req_q,
  output logic                            ext_irq0_req_q
);

  logic                    aw_held_q;
  logic                    w_held_q;
  logic [lpm_pkg::ADDR_W-1:0] waddr_q;
  logic [7:0]              wbyte_q;
  logic                    wlane_q;
  logic                    wr_fire;
  logic                    low_speed_flag_q;
  logic                    direct_transfer_flag_q;
  logic                    subosc_halt_bit_q;
  logic                    watch_select_bit_q;
  logic [1:0]              frame_sel_q;
  logic                    ram_valid_flag_q;
  logic [1:0]              wake_sync_q;
  logic [1:0]              irq0_sync_q;
  logic                    irq0_sample_q;
  logic                    irq0_level_q;
  logic                    irq0_edge_q;
  logic                    timer_a_pend_q;
  logic [lpm_pkg::CNT_W-1:0] frame_cnt_q;
  logic [lpm_pkg::CNT_W-1:0] settle_cnt_q;
  logic                    from_stop_q;
  logic                    boot_q;
  logic                    slow_mode;
  logic                    sleep_instr;
  logic                    sleep_ok;
  logic                    strobe;
  logic                    wake_watch;
  logic                    settle_done;
  logic [31:0]             rdata_d;
  logic                    raddr_ok;

  function automatic logic [lpm_pkg::CNT_W-1:0] frame_len(input logic [1:0] sel);
    unique case (sel)
      2'h1:    frame_len = lpm_pkg::CNT_W'(FRAME1_CYC);
      2'h2:    frame_len = lpm_pkg::CNT_W'(FRAME2_CYC);
      default: frame_len = lpm_pkg::CNT_W'(FRAME0_CYC);
    endcase
  endfunction

  function automatic logic [lpm_pkg::CNT_W-1:0] settle_len(input logic [1:0] sel);
    unique case (sel)
      2'h1:    settle_len = lpm_pkg::CNT_W'(SETTLE1_CYC);
      2'h2:    settle_len = lpm_pkg::CNT_W'(SETTLE2_CYC);
      default: settle_len = lpm_pkg::CNT_W'(SETTLE0_CYC);
    endcase
  endfunction

  assign slow_mode   = (mode_q == lpm_pkg::MODE_WATCH) || (mode_q == lpm_pkg::MODE_SUBACTIVE);
  assign sleep_instr = doze_instr || deep_sleep_instr;
  // A sleep with an unmasked request pending and interrupts disabled would never wake.
  assign sleep_ok    = !(!irq_global_enable && irq_unmasked_pending);
  assign wr_fire     = aw_held_q && w_held_q && !s_axi_bvalid;
  assign settle_done = settle_cnt_q == lpm_pkg::CNT_W'(1);
  // Frame code 11 is unused and falls back to the shortest frame.
  assign strobe      = slow_mode && (frame_cnt_q == frame_len(frame_sel_q) - 1'b1);
  assign wake_watch  = (mode_q == lpm_pkg::MODE_WATCH) && (timer_a_req_q || ext_irq0_req_q);

  // Write channel: address and data are taken in either order, answered once both are held.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      waddr_q       <= '0;
      wbyte_q       <= '0;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lpm_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q     <= 1'b1;
        waddr_q       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q     <= 1'b1;
        wbyte_q      <= s_axi_wdata[7:0];
        wlane_q      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (waddr_q)
          lpm_pkg::SPEED_CTRL_OFS, lpm_pkg::SYS_CLK_SEL_OFS, lpm_pkg::TIMER_A_MODE_OFS,
          lpm_pkg::FRAME_CFG_OFS, lpm_pkg::MODE_STATUS_OFS: s_axi_bresp <= lpm_pkg::RESP_OKAY;
          default:                                          s_axi_bresp <= lpm_pkg::RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Software-written control bits.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      low_speed_flag_q       <= 1'b0;
      direct_transfer_flag_q <= 1'b0;
      subosc_halt_bit_q      <= 1'b0;
      sub_speed_q            <= 1'b0;
      watch_select_bit_q     <= 1'b0;
      frame_sel_q            <= lpm_pkg::FRAME_SEL_RST;
    end
    else
    begin
      if (mode_q == lpm_pkg::MODE_ACTIVE)
        direct_transfer_flag_q <= 1'b0;
      if (wr_fire && wlane_q)
      begin
        unique case (waddr_q)
          lpm_pkg::SPEED_CTRL_OFS:
          begin
            low_speed_flag_q <= wbyte_q[lpm_pkg::LOW_SPEED_BIT];
            if (mode_q == lpm_pkg::MODE_SUBACTIVE)
              direct_transfer_flag_q <= wbyte_q[lpm_pkg::DIRECT_XFER_BIT];
          end
          lpm_pkg::SYS_CLK_SEL_OFS:
          begin
            subosc_halt_bit_q <= wbyte_q[lpm_pkg::SUBOSC_HALT_BIT];
            // The slow instruction clock must not change under a running subactive core.
            if (mode_q == lpm_pkg::MODE_ACTIVE)
              sub_speed_q <= wbyte_q[lpm_pkg::SUB_SPEED_BIT];
          end
          lpm_pkg::TIMER_A_MODE_OFS: watch_select_bit_q <= wbyte_q[lpm_pkg::WATCH_SELECT_BIT];
          lpm_pkg::FRAME_CFG_OFS:    frame_sel_q        <= wbyte_q[1:0];
          default:                   ;
        endcase
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after the address is taken.
  always_comb
  begin
    rdata_d  = '0;
    raddr_ok = 1'b1;
    unique case (s_axi_araddr)
      lpm_pkg::SPEED_CTRL_OFS:
      begin
        rdata_d[lpm_pkg::LOW_SPEED_BIT]   = low_speed_flag_q;
        rdata_d[lpm_pkg::DIRECT_XFER_BIT] = direct_transfer_flag_q;
      end
      lpm_pkg::SYS_CLK_SEL_OFS:
      begin
        rdata_d[lpm_pkg::SUBOSC_HALT_BIT] = subosc_halt_bit_q;
        rdata_d[lpm_pkg::SUB_SPEED_BIT]   = sub_speed_q;
      end
      lpm_pkg::TIMER_A_MODE_OFS: rdata_d[lpm_pkg::WATCH_SELECT_BIT] = watch_select_bit_q;
      lpm_pkg::FRAME_CFG_OFS:    ;
      lpm_pkg::MODE_STATUS_OFS:
      begin
        rdata_d[lpm_pkg::RAM_VALID_BIT]             = ram_valid_flag_q;
        rdata_d[lpm_pkg::MODE_LSB +: 3]             = mode_q;
      end
      default:                   raddr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= lpm_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= raddr_ok ? lpm_pkg::RESP_OKAY : lpm_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Both pins come from outside the clock domain.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_sync_q <= 2'h3;
      irq0_sync_q <= 2'h3;
    end
    else
    begin
      wake_sync_q <= {wake_sync_q[0], deep_sleep_wake_n};
      irq0_sync_q <= {irq0_sync_q[0], ext_irq0_n};
    end
  end

  // Interrupt frame timebase; only runs in the slow modes.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frame_cnt_q  <= '0;
      irq_strobe_q <= 1'b0;
    end
    else
    begin
      irq_strobe_q <= strobe;
      if (!slow_mode || strobe)
        frame_cnt_q <= '0;
      else
        frame_cnt_q <= frame_cnt_q + 1'b1;
    end
  end

  // Wake requests: frame-aligned in slow modes, direct otherwise.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq0_sample_q  <= 1'b1;
      irq0_level_q   <= 1'b1;
      irq0_edge_q    <= 1'b0;
      timer_a_pend_q <= 1'b0;
      timer_a_req_q  <= 1'b0;
      ext_irq0_req_q <= 1'b0;
    end
    else
    begin
      irq0_level_q <= irq0_sync_q[1];
      if (slow_mode)
      begin
        timer_a_req_q  <= strobe && (timer_a_pend_q || timer_a_overflow);
        timer_a_pend_q <= !strobe && (timer_a_pend_q || timer_a_overflow);
        if (strobe)
        begin
          irq0_sample_q  <= irq0_sync_q[1];
          irq0_edge_q    <= irq0_sample_q && !irq0_sync_q[1];
          ext_irq0_req_q <= irq0_edge_q;
        end
        else
          ext_irq0_req_q <= 1'b0;
      end
      else
      begin
        timer_a_pend_q <= 1'b0;
        timer_a_req_q  <= timer_a_overflow;
        irq0_sample_q  <= irq0_sync_q[1];
        irq0_edge_q    <= 1'b0;
        ext_irq0_req_q <= irq0_level_q && !irq0_sync_q[1];
      end
    end
  end

  // Operating mode; reset forces active from any mode.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q       <= lpm_pkg::MODE_ACTIVE;
      settle_cnt_q <= '0;
      from_stop_q  <= 1'b0;
      sleep_nop_q  <= 1'b0;
    end
    else
    begin
      sleep_nop_q <= sleep_instr && !sleep_ok && (mode_q == lpm_pkg::MODE_ACTIVE
                     || mode_q == lpm_pkg::MODE_SUBACTIVE);
      unique case (mode_q)
        lpm_pkg::MODE_ACTIVE:
          if (sleep_instr && sleep_ok)
          begin
            if (doze_instr)
              mode_q <= lpm_pkg::MODE_STANDBY;
            else if (watch_select_bit_q)
              mode_q <= lpm_pkg::MODE_WATCH;
            else
              mode_q <= lpm_pkg::MODE_STOP;
          end
        lpm_pkg::MODE_STANDBY:
          if (irq_request)
            mode_q <= lpm_pkg::MODE_ACTIVE;
        lpm_pkg::MODE_STOP:
          // The partner holds the pin low for a whole settling time; the count runs here.
          if (!wake_sync_q[1])
          begin
            mode_q       <= lpm_pkg::MODE_SETTLE;
            settle_cnt_q <= settle_len(frame_sel_q);
            from_stop_q  <= 1'b1;
          end
        lpm_pkg::MODE_WATCH:
          if (wake_watch)
          begin
            if (low_speed_flag_q)
              mode_q <= lpm_pkg::MODE_SUBACTIVE;
            else
            begin
              mode_q       <= lpm_pkg::MODE_SETTLE;
              settle_cnt_q <= settle_len(frame_sel_q);
            end
          end
        lpm_pkg::MODE_SUBACTIVE:
          if (sleep_instr && sleep_ok)
          begin
            if (!low_speed_flag_q && direct_transfer_flag_q)
            begin
              mode_q       <= lpm_pkg::MODE_SETTLE;
              settle_cnt_q <= settle_len(frame_sel_q);
            end
            else
              mode_q <= lpm_pkg::MODE_WATCH;
          end
        lpm_pkg::MODE_SETTLE:
          if (settle_done)
          begin
            mode_q      <= lpm_pkg::MODE_ACTIVE;
            from_stop_q <= 1'b0;
          end
          else
            settle_cnt_q <= settle_cnt_q - 1'b1;
        default:
          mode_q <= lpm_pkg::MODE_ACTIVE;
      endcase
    end
  end

  // Restart point and RAM valid flag; the hardware set beats a software write.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      boot_q           <= 1'b1;
      restart_zero_q   <= 1'b0;
      ram_valid_flag_q <= 1'b0;
    end
    else
    begin
      boot_q         <= 1'b0;
      restart_zero_q <= boot_q || (mode_q == lpm_pkg::MODE_SETTLE && settle_done
                        && from_stop_q);
      if (mode_q == lpm_pkg::MODE_SETTLE && settle_done && from_stop_q)
        ram_valid_flag_q <= 1'b1;
      else if (wr_fire && wlane_q && waddr_q == lpm_pkg::MODE_STATUS_OFS)
        ram_valid_flag_q <= wbyte_q[lpm_pkg::RAM_VALID_BIT];
    end
  end

  // Clock and pin control decoded from the current mode_q, so it lags mode_q by one cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      clk_ctrl_q <= '{main_osc_en: 1'b1, sub_osc_en: 1'b1, cpu_clk_en: 1'b0,
                      periph_clk_en: 1'b0, adc_clk_en: 1'b0, port_hold: 1'b0,
                      pins_hiz: 1'b1, core_reset: 1'b1};
    else
    begin
      clk_ctrl_q.main_osc_en   <= mode_q inside {lpm_pkg::MODE_ACTIVE, lpm_pkg::MODE_STANDBY,
                                                 lpm_pkg::MODE_SETTLE};
      clk_ctrl_q.sub_osc_en    <= !(mode_q == lpm_pkg::MODE_STOP && subosc_halt_bit_q);
      clk_ctrl_q.cpu_clk_en    <= mode_q inside {lpm_pkg::MODE_ACTIVE,
                                                 lpm_pkg::MODE_SUBACTIVE};
      clk_ctrl_q.periph_clk_en <= mode_q inside {lpm_pkg::MODE_ACTIVE, lpm_pkg::MODE_STANDBY,
                                                 lpm_pkg::MODE_SUBACTIVE};
      clk_ctrl_q.adc_clk_en    <= mode_q inside {lpm_pkg::MODE_ACTIVE,
                                                 lpm_pkg::MODE_STANDBY};
      clk_ctrl_q.port_hold     <= mode_q inside {lpm_pkg::MODE_STANDBY,
                                                 lpm_pkg::MODE_WATCH};
      // RAM keeps its supply in stop; only the core and pins are reset.
      clk_ctrl_q.pins_hiz      <= mode_q == lpm_pkg::MODE_STOP;
      clk_ctrl_q.core_reset    <= mode_q == lpm_pkg::MODE_STOP;
    end
  end

endmodule

// file: lpm_asserts.sv
// Port-level checks for the operating-mode sequencer.
`timescale 1ns/1ps
module lpm_asserts (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               doze_instr,
  input wire logic               deep_sleep_instr,
  input wire logic               irq_global_enable,
  input wire logic               irq_unmasked_pending,
  input wire logic               irq_request,
  input wire logic               deep_sleep_wake_n,
  input wire lpm_pkg::mode_e     mode_q,
  input wire lpm_pkg::clk_ctrl_s clk_ctrl_q,
  input wire logic               restart_zero_q,
  input wire logic               sleep_nop_q
);
  logic blk;
  logic act;
  assign blk = !irq_global_enable && irq_unmasked_pending;
  assign act = mode_q == lpm_pkg::MODE_ACTIVE;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_DOZE:
    assert property (act && doze_instr && !blk |=> mode_q == lpm_pkg::MODE_STANDBY)
    else $error("doze did not enter standby");
  AST_STBY_WAKE:
    assert property (mode_q == lpm_pkg::MODE_STANDBY && irq_request |=> act)
    else $error("standby did not wake");
  AST_NOP:
    assert property (act && (doze_instr || deep_sleep_instr) && blk |=> sleep_nop_q && act)
    else $error("blocked sleep not a no-op");
  AST_DEEP:
    assert property (act && deep_sleep_instr && !blk
      |=> mode_q inside {lpm_pkg::MODE_STOP, lpm_pkg::MODE_WATCH})
    else $error("deep sleep missed");
  AST_PIN_IGN:
    assert property (act && !deep_sleep_wake_n && !doze_instr && !deep_sleep_instr |=> act)
    else $error("cancel pin acted outside stop");
  AST_STOP_CLK:
    assert property (mode_q == lpm_pkg::MODE_STOP && $past(mode_q) == lpm_pkg::MODE_STOP
      |-> !clk_ctrl_q.main_osc_en && clk_ctrl_q.pins_hiz && clk_ctrl_q.core_reset)
    else $error("stop clocks or pins wrong");
  AST_SUB_CLK:
    assert property (mode_q == lpm_pkg::MODE_SUBACTIVE && $past(mode_q) == mode_q
      |-> !clk_ctrl_q.main_osc_en && clk_ctrl_q.sub_osc_en && !clk_ctrl_q.adc_clk_en)
    else $error("subactive clocks wrong");
  AST_SETTLE:
    assert property (mode_q == lpm_pkg::MODE_SETTLE && $past(mode_q) != mode_q
      |-> ##[1:30] act)
    else $error("settle too long");
  AST_RESTART:
    assert property (restart_zero_q |=> !restart_zero_q)
    else $error("restart pulse too long");
endmodule

// file: wake_pins.sv
// Far-side pin model: stop-cancel and external interrupt 0 drivers.
`timescale 1ns/1ps
module wake_pins (
  input  wire logic clk,
  input  wire logic wake_go,
  input  wire logic irq0_go,
  output logic      deep_sleep_wake_n,
  output logic      ext_irq0_n
);
  logic [7:0] wake_q = 8'h00;
  logic [7:0] irq_q  = 8'h00;
  always_ff @(posedge clk)
  begin
    wake_q <= wake_go ? 8'h0c : wake_q - {7'h00, wake_q != 8'h00};
  end
  always_ff @(posedge clk)
  begin
    irq_q <= irq0_go ? 8'h46 : irq_q - {7'h00, irq_q != 8'h00};
  end
  // Both pins are pulled up; cancel outlasts the 8-cycle settle of frame code 0, the only one the bench uses with stop.
  assign deep_sleep_wake_n = wake_q == 8'h00;
  // Low for 70 cycles outlasts the 40-cycle frame of code 1, the longest the bench uses, or the per-frame sampler could miss it.
  assign ext_irq0_n = irq_q == 8'h00;
endmodule

// file: tb.sv
// Self-checking bench for the operating-mode sequencer.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
  logic clk = 1'h0, rst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, doze_instr = 1'h0, deep_sleep_instr = 1'h0;
  logic irq_global_enable = 1'h1, irq_unmasked_pending = 1'h0, irq_request = 1'h0;
  logic timer_a_overflow = 1'h0, wake_go = 1'h0, irq0_go = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, deep_sleep_wake_n;
  logic ext_irq0_n, sub_speed_q, restart_zero_q, sleep_nop_q, irq_strobe_q, timer_a_req_q;
  logic ext_irq0_req_q;
  lpm_pkg::mode_e mode_q;
  lpm_pkg::clk_ctrl_s clk_ctrl_q;
  int miscompares = 0, n_tests = 0, cyc = 0, restarts = 0, n, k;

  always #25 clk = ~clk;
  low_power_mode_sequencer #(.FRAME0_CYC(20), .FRAME1_CYC(40), .SETTLE0_CYC(8),
    .SETTLE1_CYC(16)) i_low_power_mode_sequencer (.clk,
    .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .doze_instr, .deep_sleep_instr, .irq_global_enable, .irq_unmasked_pending, .irq_request,
    .timer_a_overflow, .deep_sleep_wake_n, .ext_irq0_n, .mode_q, .clk_ctrl_q, .sub_speed_q,
    .restart_zero_q, .sleep_nop_q, .irq_strobe_q, .timer_a_req_q, .ext_irq0_req_q);
  wake_pins i_wake_pins (.clk, .wake_go, .irq0_go, .deep_sleep_wake_n, .ext_irq0_n);

  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (restart_zero_q) restarts++;
    if ((timer_a_req_q || ext_irq0_req_q) && mode_q inside {lpm_pkg::MODE_WATCH,
        lpm_pkg::MODE_SUBACTIVE}) `CHK(irq_strobe_q, 1'h1)
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      rs = s_axi_bresp;
      if (s_axi_bvalid) s_axi_bready <= 1'h0;
      if (s_axi_bvalid) break;
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      if (s_axi_rvalid) s_axi_rready <= 1'h0;
      if (s_axi_rvalid) break;
    end
  endtask
  task automatic pulse(input int p);
    @(posedge clk);
    case (p)
      0: irq_request <= 1'h1;
      1: timer_a_overflow <= 1'h1;
      2: wake_go <= 1'h1;
      default: irq0_go <= 1'h1;
    endcase
    @(posedge clk);
    {irq_request, timer_a_overflow, wake_go, irq0_go} <= 4'h0;
  endtask
  task automatic instr(input bit d);
    @(posedge clk);
    if (d) deep_sleep_instr <= 1'h1;
    else doze_instr <= 1'h1;
    @(posedge clk);
    {deep_sleep_instr, doze_instr} <= 2'h0;
    @(negedge clk);
  endtask
  task automatic wait_mode(input lpm_pkg::mode_e m);
    for (n = 0; mode_q !== m && n < 300; n++) @(posedge clk);
  endtask
  task automatic t_regs();
    rdr(lpm_pkg::MODE_STATUS_OFS);
    `CHK(rd[lpm_pkg::RAM_VALID_BIT], 1'h0)
    `CHK(restarts, 1)
    rdr(lpm_pkg::FRAME_CFG_OFS);
    `CHK(rd, 32'h0000_0000)
    rdr(8'h20);
    `CHK(rs, lpm_pkg::RESP_SLVERR)
    wr(8'h20, 32'h0000_0001);
    `CHK(rs, lpm_pkg::RESP_SLVERR)
    s_axi_wstrb <= 4'h0;
    wr(lpm_pkg::TIMER_A_MODE_OFS, 32'h0000_0008);
    s_axi_wstrb <= 4'hf;
    rdr(lpm_pkg::TIMER_A_MODE_OFS);
    `CHK(rd, 32'h0000_0000)
  endtask
  task automatic t_standby();
    instr(0);
    `CHK(mode_q, lpm_pkg::MODE_STANDBY)
    @(negedge clk);
    `CHK({clk_ctrl_q.main_osc_en, clk_ctrl_q.cpu_clk_en, clk_ctrl_q.port_hold}, 3'h5)
    pulse(0);
    wait_mode(lpm_pkg::MODE_ACTIVE);
    `CHK(mode_q, lpm_pkg::MODE_ACTIVE)
  endtask
  task automatic t_nop();
    irq_global_enable <= 1'h0;
    irq_unmasked_pending <= 1'h1;
    for (k = 0; k < 2; k++)
    begin
      instr(k[0]);
      `CHK({sleep_nop_q, mode_q}, {1'h1, lpm_pkg::MODE_ACTIVE})
    end
    irq_global_enable <= 1'h1;
    irq_unmasked_pending <= 1'h0;
  endtask
  task automatic t_stop();
    pulse(2);
    repeat (20) @(posedge clk);
    `CHK(mode_q, lpm_pkg::MODE_ACTIVE)
    wr(lpm_pkg::SYS_CLK_SEL_OFS, 32'h0000_0008);
    instr(1);
    `CHK(mode_q, lpm_pkg::MODE_STOP)
    @(negedge clk);
    `CHK({clk_ctrl_q.sub_osc_en, clk_ctrl_q.pins_hiz, clk_ctrl_q.core_reset}, 3'h3)
    pulse(2);
    wait_mode(lpm_pkg::MODE_ACTIVE);
    rdr(lpm_pkg::MODE_STATUS_OFS);
    `CHK({rd[lpm_pkg::RAM_VALID_BIT], restarts}, {1'h1, 32'h0000_0002})
  endtask
  task automatic t_watch();
    wr(lpm_pkg::SYS_CLK_SEL_OFS, 32'h0000_0000);
    wr(lpm_pkg::TIMER_A_MODE_OFS, 32'h0000_0008);
    for (k = 0; k < 3; k++)
    begin
      repeat (150) @(posedge clk);
      wr(lpm_pkg::FRAME_CFG_OFS, k + k / 2);
      instr(1);
      `CHK(mode_q, lpm_pkg::MODE_WATCH)
      pulse(3);
      wait_mode(lpm_pkg::MODE_ACTIVE);
      `CHK(n >= 28 * (k % 2 + 1) && n <= 48 * (k % 2 + 1) + 6, 1'h1)
    end
  endtask
  task automatic t_sub();
    wr(lpm_pkg::FRAME_CFG_OFS, 32'h0000_0000);
    wr(lpm_pkg::SPEED_CTRL_OFS, 32'h0000_0001);
    instr(1);
    for (k = 0; k < 2; k++)
    begin
      pulse(1);
      wait_mode(lpm_pkg::MODE_SUBACTIVE);
      `CHK(mode_q, lpm_pkg::MODE_SUBACTIVE)
      wr(lpm_pkg::SYS_CLK_SEL_OFS, 32'h0000_0004);
      `CHK(sub_speed_q, 1'h0)
      if (k == 0) instr(0);
      if (k == 0) `CHK(mode_q, lpm_pkg::MODE_WATCH)
    end
    wr(lpm_pkg::SPEED_CTRL_OFS, 32'h0000_0008);
    instr(0);
    wait_mode(lpm_pkg::MODE_ACTIVE);
    `CHK(mode_q, lpm_pkg::MODE_ACTIVE)
    rdr(lpm_pkg::SPEED_CTRL_OFS);
    `CHK(rd[lpm_pkg::DIRECT_XFER_BIT], 1'h0)
    wr(lpm_pkg::SYS_CLK_SEL_OFS, 32'h0000_0004);
    `CHK(sub_speed_q, 1'h1)
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_standby();
    t_nop();
    t_stop();
    t_watch();
    t_sub();
    instr(0);
    rst <= 1'h1;
    @(negedge clk);
    `CHK(mode_q, lpm_pkg::MODE_ACTIVE)
    give_verdict();
  end
endmodule

bind low_power_mode_sequencer lpm_asserts i_lpm_asserts (.clk, .rst, .doze_instr,
  .deep_sleep_instr, .irq_global_enable, .irq_unmasked_pending, .irq_request,
  .deep_sleep_wake_n, .mode_q, .clk_ctrl_q, .restart_zero_q, .sleep_nop_q);
